// >>> hdl/xo_drv_cfg.sv
// Local design decisions: register access over APB and the placing of the registers.
`include "xo_drv_params.svh"
//Behaviour
// - osc regulator enable bit 16, resets one
// - startup boost amplifier count, resets one
// - output-pin tuning code, max 0x2f, resets 0x1f
// - input-pin tuning code, max 0x2f, resets 0x1f
// - divider ratio 14 bits, resets 0x69, min 10
// - divider regulator enable bit 15, resets one
// - disable bit forces driver disabled
// - disabled pins follow the disable state code
// - power down tri-states pins, ignores enable
// - cmos phasing field selects pin drive
// - driver type: hcsl, reserved, lvds, cmos
// - lvds common mode level code, resets two
// - hcsl termination enable, resets one
// - bias enable bit 2, resets one
module xo_drv_cfg (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  input  wire logic        output_enable_i,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             osc_regulator_on_o,
  output logic      [1:0]  osc_boost_count_o,
  output logic      [5:0]  osc_cap_out_code_o,
  output logic      [5:0]  osc_cap_in_code_o,
  output logic             divider_regulator_on_o,
  output logic             driver_bias_on_o,
  output logic             hcsl_term_on_o,
  output logic      [1:0]  common_mode_level_o,
  output logic             clock_pin_true_o,
  output logic             clock_pin_complement_o,
  output logic             clock_pin_true_oe_n_o,
  output logic             clock_pin_complement_oe_n_o
);
  logic [31:0] xo_cfg_reg;
  logic [31:0] xo_cfg_next;
  logic [31:0] div_cfg_reg;
  logic [31:0] div_cfg_next;
  logic [31:0] drv_en_reg;
  logic [31:0] drv_en_next;
  logic [31:0] drv_style_reg;
  logic [31:0] drv_style_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pready_reg;
  logic        pready_next;
  logic        pslverr_reg;
  logic        pslverr_next;
  logic [31:0] strb_mask;
  logic        hit;
  logic        div_level;
  logic        drv_disabled;
  logic        pin_true;
  logic        pin_comp;
  logic        pin_true_oe_n;
  logic        pin_comp_oe_n;
  logic [5:0]  pins_reg;
  logic [5:0]  pins_next;

  // byte strobes widened to a bit mask
  assign strb_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  // apb slave: one wait state, answer in the access phase's second cycle
  always_comb begin
    xo_cfg_next    = xo_cfg_reg;
    div_cfg_next   = div_cfg_reg;
    drv_en_next    = drv_en_reg;
    drv_style_next = drv_style_reg;
    prdata_next    = prdata_reg;
    pready_next    = 1'b0;
    pslverr_next   = 1'b0;
    hit            = 1'b1;
    if (psel && penable && !pready_reg) begin
      pready_next = 1'b1;
      prdata_next = 32'h0000_0000;
      case (paddr)
        `OFF_XO_CFG: begin
          prdata_next = xo_cfg_reg;
          if (pwrite)
            xo_cfg_next = (xo_cfg_reg & ~(strb_mask & `MASK_XO_CFG)) | (pwdata & strb_mask & `MASK_XO_CFG);
        end
        `OFF_DIV_CFG: begin
          prdata_next = div_cfg_reg;
          if (pwrite)
            div_cfg_next = (div_cfg_reg & ~(strb_mask & `MASK_DIV_CFG)) | (pwdata & strb_mask & `MASK_DIV_CFG);
        end
        `OFF_DRV_EN: begin
          prdata_next = drv_en_reg;
          if (pwrite)
            drv_en_next = (drv_en_reg & ~(strb_mask & `MASK_DRV_EN)) | (pwdata & strb_mask & `MASK_DRV_EN);
        end
        `OFF_DRV_STYLE: begin
          prdata_next = drv_style_reg;
          if (pwrite)
            drv_style_next = (drv_style_reg & ~(strb_mask & `MASK_DRV_STYLE)) | (pwdata & strb_mask & `MASK_DRV_STYLE);
        end
        `OFF_PIN_STATUS: prdata_next = {26'h000_0000, pins_reg}; // read only
        default: hit = 1'b0;
      endcase
      pslverr_next = !hit;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      xo_cfg_reg    <= `RST_XO_CFG;
      div_cfg_reg   <= `RST_DIV_CFG;
      drv_en_reg    <= `RST_DRV_EN;
      drv_style_reg <= `RST_DRV_STYLE;
      prdata_reg    <= 32'h0000_0000;
      pready_reg    <= 1'b0;
      pslverr_reg   <= 1'b0;
    end else begin
      xo_cfg_reg    <= xo_cfg_next;
      div_cfg_reg   <= div_cfg_next;
      drv_en_reg    <= drv_en_next;
      drv_style_reg <= drv_style_next;
      prdata_reg    <= prdata_next;
      pready_reg    <= pready_next;
      pslverr_reg   <= pslverr_next;
    end
  end

  // disable bit or a low enable input takes the driver off; reserved type counts as disabled
  assign drv_disabled = drv_en_reg[`EN_DIS_BIT] || !output_enable_i ||
                        (drv_style_reg[`ST_TYPE_HI:`ST_TYPE_LO] == xo_drv_pkg::drv_rsvd);

  // divider only runs while its regulator and the driver are powered
  out_divider #(
    .RATIO_W(14)
  ) u_div (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .run_i   (div_cfg_reg[`DIV_REG_BIT] && !drv_en_reg[`EN_PD_BIT]),
    .ratio_i (div_cfg_reg[`DIV_RATIO_HI:`DIV_RATIO_LO]),
    .level_o (div_level)
  );

  pin_driver u_pins (
    .clk_level_i  (div_level),
    .disabled_i   (drv_disabled),
    .power_down_i (drv_en_reg[`EN_PD_BIT]),
    .kind_i       (xo_drv_pkg::drv_kind_type'(drv_style_reg[`ST_TYPE_HI:`ST_TYPE_LO])),
    .dis_state_i  (xo_drv_pkg::dis_state_type'(drv_en_reg[`EN_STATE_HI:`EN_STATE_LO])),
    .phase_i      (xo_drv_pkg::cmos_phase_type'(drv_style_reg[`ST_PHASE_HI:`ST_PHASE_LO])),
    .true_o       (pin_true),
    .comp_o       (pin_comp),
    .true_oe_n_o  (pin_true_oe_n),
    .comp_oe_n_o  (pin_comp_oe_n)
  );

  // pin status snapshot for software: levels, oe_n pair, divider level, disabled
  assign pins_next = {drv_disabled, div_level, pin_comp_oe_n, pin_true_oe_n, pin_comp, pin_true};

  // all analog controls and pins leave through flip-flops
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pins_reg                    <= 6'h0c;
      osc_regulator_on_o          <= 1'b1;
      osc_boost_count_o           <= 2'h1;
      osc_cap_out_code_o          <= 6'h1f;
      osc_cap_in_code_o           <= 6'h1f;
      divider_regulator_on_o      <= 1'b1;
      driver_bias_on_o            <= 1'b1;
      hcsl_term_on_o              <= 1'b1;
      common_mode_level_o         <= 2'h2;
      clock_pin_true_o            <= 1'b0;
      clock_pin_complement_o      <= 1'b0;
      clock_pin_true_oe_n_o       <= 1'b1;
      clock_pin_complement_oe_n_o <= 1'b1;
    end else begin
      pins_reg                    <= pins_next;
      osc_regulator_on_o          <= xo_cfg_reg[`XO_REG_BIT];
      osc_boost_count_o           <= xo_cfg_reg[`XO_BOOST_HI:`XO_BOOST_LO];
      // reserved capacitor codes are clamped to the top valid step
      osc_cap_out_code_o          <= (xo_cfg_reg[`XO_CAPO_HI:`XO_CAPO_LO] > `CAP_CODE_MAX) ?
                                     `CAP_CODE_MAX : xo_cfg_reg[`XO_CAPO_HI:`XO_CAPO_LO];
      osc_cap_in_code_o           <= (xo_cfg_reg[`XO_CAPI_HI:`XO_CAPI_LO] > `CAP_CODE_MAX) ?
                                     `CAP_CODE_MAX : xo_cfg_reg[`XO_CAPI_HI:`XO_CAPI_LO];
      divider_regulator_on_o      <= div_cfg_reg[`DIV_REG_BIT];
      driver_bias_on_o            <= drv_style_reg[`ST_BIAS_BIT];
      hcsl_term_on_o              <= drv_style_reg[`ST_TERM_BIT] &&
                                     (drv_style_reg[`ST_TYPE_HI:`ST_TYPE_LO] == xo_drv_pkg::drv_hcsl);
      common_mode_level_o         <= drv_style_reg[`ST_CM_HI:`ST_CM_LO];
      clock_pin_true_o            <= pin_true;
      clock_pin_complement_o      <= pin_comp;
      clock_pin_true_oe_n_o       <= pin_true_oe_n;
      clock_pin_complement_oe_n_o <= pin_comp_oe_n;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
endmodule

// >>> hdl/xo_drv_params.svh
`ifndef XO_DRV_PARAMS_SVH
`define XO_DRV_PARAMS_SVH
// register byte offsets on the apb bus
`define OFF_XO_CFG        12'h000
`define OFF_DIV_CFG       12'h004
`define OFF_DRV_EN        12'h008
`define OFF_DRV_STYLE     12'h00c
`define OFF_PIN_STATUS    12'h010
// writable bit masks per register
`define MASK_XO_CFG       32'h0007_ffff
`define MASK_DIV_CFG      32'h0000_bfff
`define MASK_DRV_EN       32'h0000_000f
`define MASK_DRV_STYLE    32'h0000_00ff
// reset values
`define RST_XO_CFG        32'h0001_5f1f
`define RST_DIV_CFG       32'h0000_8069
`define RST_DRV_EN        32'h0000_0000
`define RST_DRV_STYLE     32'h0000_006c
// field positions
`define XO_REG_BIT        16
`define XO_BOOST_HI       15
`define XO_BOOST_LO       14
`define XO_CAPO_HI        13
`define XO_CAPO_LO        8
`define XO_CAPI_HI        5
`define XO_CAPI_LO        0
`define DIV_REG_BIT       15
`define DIV_RATIO_HI      13
`define DIV_RATIO_LO      0
`define EN_STATE_HI       3
`define EN_STATE_LO       2
`define EN_DIS_BIT        1
`define EN_PD_BIT         0
`define ST_PHASE_HI       7
`define ST_PHASE_LO       6
`define ST_CM_HI          5
`define ST_CM_LO          4
`define ST_TERM_BIT       3
`define ST_BIAS_BIT       2
`define ST_TYPE_HI        1
`define ST_TYPE_LO        0
// limits
`define CAP_CODE_MAX      6'h2f
`define DIV_RATIO_MIN     14'h000a
`endif

// >>> hdl/xo_drv_pkg.sv
package xo_drv_pkg;
  typedef enum logic [1:0] {
    drv_hcsl = 2'b00,
    drv_rsvd = 2'b01,
    drv_lvds = 2'b10,
    drv_cmos = 2'b11
  } drv_kind_type;
  typedef enum logic [1:0] {
    dis_low_low  = 2'b00,
    dis_low_high = 2'b01,
    dis_hiz      = 2'b10,
    dis_toggle   = 2'b11
  } dis_state_type;
  typedef enum logic [1:0] {
    ph_same  = 2'b00,
    ph_opp   = 2'b01,
    ph_true  = 2'b10,
    ph_comp  = 2'b11
  } cmos_phase_type;
endpackage

// >>> hdl/out_divider.sv
`include "xo_drv_params.svh"
// divides the clock by ratio, producing a level high for ratio/2 cycles, rounded down
module out_divider #(
  parameter int RATIO_W = 14
) (
  input  wire logic               clock_i,
  input  wire logic               rst_i,
  input  wire logic               run_i,
  input  wire logic [RATIO_W-1:0] ratio_i,
  output logic                    level_o
);
  logic [RATIO_W-1:0] count_reg;
  logic [RATIO_W-1:0] count_next;
  logic               level_reg;
  logic               level_next;
  logic [RATIO_W-1:0] ratio_eff;

  // ratios below the minimum are clamped so the divider never runs too fast
  always_comb begin
    ratio_eff = (ratio_i < `DIV_RATIO_MIN) ? `DIV_RATIO_MIN : ratio_i;
    count_next = count_reg;
    level_next = level_reg;
    if (!run_i) begin
      count_next = '0;
      level_next = 1'b0;
    end else if (count_reg >= ratio_eff - 14'h0001) begin
      count_next = '0;
      level_next = 1'b1;
    end else begin
      count_next = count_reg + 14'h0001;
      if (count_reg == (ratio_eff >> 1) - 14'h0001) level_next = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      count_reg <= '0;
      level_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      level_reg <= level_next;
    end
  end

  assign level_o = level_reg;
endmodule

// >>> hdl/pin_driver.sv
// maps the divided clock and the driver controls onto the two pins
module pin_driver (
  input  wire logic                      clk_level_i,
  input  wire logic                      disabled_i,
  input  wire logic                      power_down_i,
  input  wire xo_drv_pkg::drv_kind_type  kind_i,
  input  wire xo_drv_pkg::dis_state_type dis_state_i,
  input  wire xo_drv_pkg::cmos_phase_type phase_i,
  output logic                           true_o,
  output logic                           comp_o,
  output logic                           true_oe_n_o,
  output logic                           comp_oe_n_o
);
  // power down wins over everything, then disable state, then normal drive
  always_comb begin
    true_o      = clk_level_i;
    comp_o      = ~clk_level_i;
    true_oe_n_o = 1'b0;
    comp_oe_n_o = 1'b0;
    if (kind_i == xo_drv_pkg::drv_cmos) begin
      case (phase_i)
        xo_drv_pkg::ph_same: comp_o = clk_level_i;
        xo_drv_pkg::ph_opp:  comp_o = ~clk_level_i;
        xo_drv_pkg::ph_true: comp_o = 1'b0;
        xo_drv_pkg::ph_comp: true_o = 1'b0;
        default:             comp_o = ~clk_level_i;
      endcase
    end
    if (power_down_i) begin
      true_o      = 1'b0;
      comp_o      = 1'b0;
      true_oe_n_o = 1'b1;
      comp_oe_n_o = 1'b1;
    end else if (disabled_i) begin
      case (dis_state_i)
        xo_drv_pkg::dis_low_low: begin
          true_o = 1'b0;
          comp_o = (kind_i == xo_drv_pkg::drv_lvds);
        end
        xo_drv_pkg::dis_low_high: begin
          true_o = 1'b0;
          comp_o = 1'b1;
        end
        xo_drv_pkg::dis_hiz: begin
          true_o      = 1'b0;
          comp_o      = 1'b0;
          true_oe_n_o = 1'b1;
          comp_oe_n_o = 1'b1;
        end
        default: ; // debug: keep toggling
      endcase
    end
  end
endmodule

// >>> dv/xo_drv_cfg_checker.sv
`include "xo_drv_params.svh"
// shadows the enable and style registers from completed writes, then ties outputs to them
module xo_drv_cfg_checker (
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        driver_bias_on_o,
  input wire logic        hcsl_term_on_o,
  input wire logic [1:0]  common_mode_level_o,
  input wire logic        clock_pin_true_o,
  input wire logic        clock_pin_complement_o,
  input wire logic        clock_pin_true_oe_n_o,
  input wire logic        clock_pin_complement_oe_n_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic [7:0] en_reg, en_next, st_reg, st_next;
  logic       wr;
  // a write lands only on the completing edge of a mapped access
  assign wr = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
  always_comb begin
    en_next = en_reg;
    st_next = st_reg;
    if (wr && paddr == `OFF_DRV_EN) en_next = pwdata[7:0] & 8'h0f;
    if (wr && paddr == `OFF_DRV_STYLE) st_next = pwdata[7:0];
  end
  always_ff @(posedge clock_i) begin
    en_reg <= rst_i ? 8'h00 : en_next;
    st_reg <= rst_i ? 8'h6c : st_next;
  end
  // four cycles cover the one-cycle pin lag with margin
  sequence s_setup_access;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence s_held_low;
    (en_reg[3:0] == 4'h2 && st_reg[1:0] == 2'h0) [*4];
  endsequence
  sequence s_held_hiz;
    (en_reg[3:0] == 4'ha) [*4];
  endsequence
  sequence s_powered_down;
    en_reg[0] [*4];
  endsequence
  a_ready_one_wait: assert property (s_setup_access |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_err_unmapped: assert property (pready |-> pslverr == (paddr > `OFF_PIN_STATUS))
    else $error("pslverr wrong");
  a_pd_tristate: assert property (s_powered_down |-> clock_pin_true_oe_n_o && clock_pin_complement_oe_n_o)
    else $error("power down drives");
  a_hiz_state: assert property (s_held_hiz |-> clock_pin_true_oe_n_o && clock_pin_complement_oe_n_o)
    else $error("hiz state drives");
  a_disabled_low: assert property (s_held_low |-> {clock_pin_true_oe_n_o, clock_pin_complement_oe_n_o,
    clock_pin_true_o, clock_pin_complement_o} == 4'h0) else $error("disabled not low");
  a_bias_follow: assert property ($stable(st_reg) |-> driver_bias_on_o == st_reg[2])
    else $error("bias wrong");
  a_cm_follow: assert property ($stable(st_reg) |-> common_mode_level_o == st_reg[5:4])
    else $error("common mode wrong");
  a_term_hcsl: assert property ($stable(st_reg) |-> hcsl_term_on_o == (st_reg[3] && st_reg[1:0] == 2'h0))
    else $error("termination wrong");
endmodule
bind xo_drv_cfg xo_drv_cfg_checker xo_drv_cfg_checker_i (.clock_i(clock_i), .rst_i(rst_i), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
  .pslverr(pslverr), .driver_bias_on_o(driver_bias_on_o), .hcsl_term_on_o(hcsl_term_on_o),
  .common_mode_level_o(common_mode_level_o), .clock_pin_true_o(clock_pin_true_o),
  .clock_pin_complement_o(clock_pin_complement_o), .clock_pin_true_oe_n_o(clock_pin_true_oe_n_o),
  .clock_pin_complement_oe_n_o(clock_pin_complement_oe_n_o));

// >>> dv/tb_top.sv
`include "xo_drv_params.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0, output_enable_i = 1;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0]  pstrb = 0;
  logic        pready, pslverr, err, reg_on, div_on, bias_on, term_on, pt, pc, pt_n, pc_n;
  logic [1:0]  boost, cm;
  logic [5:0]  cap_o, cap_i, co, ci;
  int          errors = 0, checks = 0;
  always #5 clock_i = ~clock_i;
  xo_drv_cfg xo_drv_cfg_i (.clock_i(clock_i), .rst_i(rst_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .output_enable_i(output_enable_i), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .osc_regulator_on_o(reg_on), .osc_boost_count_o(boost),
    .osc_cap_out_code_o(cap_o), .osc_cap_in_code_o(cap_i), .divider_regulator_on_o(div_on),
    .driver_bias_on_o(bias_on), .hcsl_term_on_o(term_on), .common_mode_level_o(cm),
    .clock_pin_true_o(pt), .clock_pin_complement_o(pc), .clock_pin_true_oe_n_o(pt_n),
    .clock_pin_complement_oe_n_o(pc_n));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; the wait for pready is bounded so a dead slave cannot hang us
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= 4'hf; penable <= 1'b0;
    @(posedge clock_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20) errors++;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clock_i);
  endtask
  // reset values, writable masks, and a refused access
  task automatic t_regs;
    logic [11:0] a[4] = '{`OFF_XO_CFG, `OFF_DIV_CFG, `OFF_DRV_EN, `OFF_DRV_STYLE};
    logic [31:0] v[4] = '{32'h0001_5f1f, 32'h0000_8069, 32'h0000_0000, 32'h0000_006c};
    logic [31:0] m[4] = '{32'h0007_ffff, 32'h0000_bfff, 32'h0000_000f, 32'h0000_00ff};
    chk(32'({reg_on, boost, cap_o, cap_i, div_on, bias_on, term_on, cm}), 32'h000a_fbfe);
    for (int i = 0; i < 4; i++) begin
      apb(a[i], 1'b0, 32'h0);
      chk(rd, v[i]);
      apb(a[i], 1'b1, 32'hffff_ffff);
      apb(a[i], 1'b0, 32'h0);
      chk(rd, m[i]);
      apb(a[i], 1'b1, v[i]);
    end
    apb(12'h014, 1'b0, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
  endtask
  // every boost count, with cap codes crossing the reserved boundary
  task automatic t_xo;
    logic [31:0] wv;
    for (int i = 0; i < 4; i++) begin
      co = 6'h2e + 6'(i);
      ci = 6'h2c + 6'(2 * i);
      wv = {15'h0, i[0], i[1:0], co, 2'h0, ci};
      apb(`OFF_XO_CFG, 1'b1, wv);
      apb(`OFF_XO_CFG, 1'b0, 32'h0);
      chk(rd, wv);
      chk(32'({reg_on, boost, cap_o, cap_i}),
        32'({i[0], i[1:0], (co > 6'h2f) ? 6'h2f : co, (ci > 6'h2f) ? 6'h2f : ci}));
    end
    apb(`OFF_DIV_CFG, 1'b1, 32'h0000_000a);
    apb(`OFF_DIV_CFG, 1'b0, 32'h0);
    chk(rd, 32'h0000_000a);
    chk({31'h0, div_on}, 32'h0);
    apb(`OFF_DIV_CFG, 1'b1, 32'h0000_800a);
  endtask
  // lvds common mode codes with bias toggling; termination stays off outside hcsl
  task automatic t_style;
    for (int c = 0; c < 4; c++) begin
      apb(`OFF_DRV_STYLE, 1'b1, {24'h0, 2'h1, 2'(c), 1'b1, c[0], 2'h2});
      chk(32'({cm, bias_on, term_on}), 32'({2'(c), c[0], 1'b0}));
    end
  endtask
  // disabled states, power down, outside enable and the reserved type; {mask, value} of oe_n and pins
  task automatic t_pins;
    logic [7:0] st[7] = '{8'h6c, 8'h6e, 8'h6c, 8'h6c, 8'h6c, 8'h6d, 8'h6c};
    logic [3:0] en[7] = '{4'h2, 4'h2, 4'h6, 4'ha, 4'h4, 4'h4, 4'h5};
    logic [7:0] ex[7] = '{8'hf0, 8'hf1, 8'hf1, 8'hcc, 8'hf1, 8'hf1, 8'hcc};
    for (int i = 0; i < 7; i++) begin
      output_enable_i <= (i != 4);
      apb(`OFF_DRV_STYLE, 1'b1, {24'h0, st[i]});
      apb(`OFF_DRV_EN, 1'b1, {28'h0, en[i]});
      repeat (4) @(posedge clock_i);
      chk({28'h0, {pt_n, pc_n, pt, pc} & ex[i][7:4]}, {28'h0, ex[i][3:0]});
      if (i == 6) begin
        apb(`OFF_PIN_STATUS, 1'b0, 32'h0);
        chk(rd, 32'h0000_000c);
      end
    end
    output_enable_i <= 1'b1;
    apb(`OFF_DRV_EN, 1'b1, 32'h0);
  endtask
  // cmos phasing sampled across more than one divided period
  task automatic t_cmos;
    logic [1:0] seen;
    for (int p = 0; p < 4; p++) begin
      apb(`OFF_DRV_STYLE, 1'b1, {24'h0, 2'(p), 6'h2f});
      seen = 2'b00;
      repeat (12) begin
        @(posedge clock_i);
        chk({28'h0, pt_n, pc_n, pt, pc}, {28'h0, 2'h0, p == 3 ? 1'b0 : pt,
          p == 2 ? 1'b0 : (p == 0 ? pt : (p == 1 ? ~pt : pc))});
        seen = seen | {((p == 3) ? pc : pt), ~((p == 3) ? pc : pt)};
      end
      chk({30'h0, seen}, 32'h0000_0003);
    end
  endtask
  // a mid-run reset must bring written fields back to their reset values
  task automatic t_reset;
    apb(`OFF_XO_CFG, 1'b1, 32'h0000_0000);
    rst_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    chk({31'h0, reg_on}, 32'h0000_0001);
    apb(`OFF_XO_CFG, 1'b0, 32'h0);
    chk(rd, 32'h0001_5f1f);
  endtask
  task automatic print_verdict;
    if (errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // main sequence after four cycles of reset
  initial begin
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    t_regs();
    t_xo();
    t_style();
    t_pins();
    t_cmos();
    t_reset();
    print_verdict();
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #100us;
    errors++;
    print_verdict();
  end
endmodule
